//--- lac_chan_a_regs.sv
// Channel A config and status registers with the receiver-detect probe sequencer.
// Assumes an SMBus slave outside presents byte accesses synchronous to clk.
//
// Function
// - Detect code 00: input high impedance, no probing at all.
// - Code 01: probe every 12 ms, stop after 50 tries; 50 ohm once found.
// - Code 10: probe every 12 ms without limit; 50 ohm once found.
// - Code 11: fixed 50 ohm termination, pin setting overridden only while the global detect override is set.
// - Equalizer gain: 8-bit read/write, 256 levels, resets to 0x2f.
// - Rate control bit 7 switches output short-circuit protection on or off.
// - Rate control bit 6 picks gen1/2 when 1, gen3 when 0; resets 0xed.
// - Read-only bits 6:5 report detected rate: 00, 01 or 11.
// - Forced rate applies only while the global rate override is set.
// - Register detect mode applies only while the global detect override is set.
`include "lac_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module lac_chan_a_regs
  import lac_pkg::*;
#(
  parameter int PROBE_CYCLES = `LAC_PROBE_CYCLES,
  parameter int PROBE_ATTEMPTS = `LAC_PROBE_ATTEMPTS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port from the SMBus slave
  input wire lac_reg_req_type regReq,
  output logic [7:0] regRdData,
  // Global overrides and pin settings
  input wire logic overrideRxDet,
  input wire logic overrideRate,
  input wire logic [1:0] rxDetPinMode,
  input wire logic autoGen12,
  // Analog link side
  input wire logic receiverSeen,
  input wire logic [1:0] detectedRate,
  output lac_link_type link,
  output logic scpEnable,
  output logic gen12Select,
  output logic [7:0] equalizerGainLevel
);

  localparam int TW = $clog2(PROBE_CYCLES + 1);
  localparam int AW = $clog2(PROBE_ATTEMPTS + 1);

  if (PROBE_CYCLES < 2 || PROBE_ATTEMPTS < 1)
  begin : gen_check
    $error("lac_chan_a_regs: probe period or attempt count too small");
  end

  logic [7:0] rsvdB_ff;
  logic [7:0] rsvdC_ff;
  logic [7:0] rsvdD_ff;
  logic [1:0] rxMode_ff;
  logic [7:0] eqGain_ff;
  logic [7:0] rateReg_ff;
  logic [1:0] rateSeen_ff;
  logic [7:0] rdData_ff;
  lac_state_type state_ff;
  lac_state_type nxt_state;
  logic [1:0] lastMode_ff;
  logic [TW-1:0] timer_ff;
  logic [AW-1:0] attempts_ff;
  logic probe_ff;
  logic term50_ff;
  logic gen12_ff;
  logic [1:0] effMode;
  logic timerDone;
  logic modeChanged;

  // Register writes; unmapped offsets are ignored
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rsvdB_ff <= `LAC_RST_RSVD_B;
      rsvdC_ff <= `LAC_RST_RSVD_C;
      rsvdD_ff <= `LAC_RST_RSVD_D;
      rxMode_ff <= `LAC_RST_RECEIVER_DETECT_MODE;
      eqGain_ff <= `LAC_RST_EQ;
      rateReg_ff <= `LAC_RST_RATE;
    end
    else if (regReq.wrEn)
    begin
      case (regReq.addr)
        `LAC_OFS_RSVD_B: rsvdB_ff <= regReq.data;
        `LAC_OFS_RSVD_C: rsvdC_ff <= regReq.data;
        `LAC_OFS_RSVD_D: rsvdD_ff <= regReq.data;
        `LAC_OFS_RECEIVER_DETECT_MODE: rxMode_ff <= regReq.data[`LAC_RECEIVER_DETECT_MODE_HI:`LAC_RECEIVER_DETECT_MODE_LO];
        `LAC_OFS_EQ: eqGain_ff <= regReq.data;
        `LAC_OFS_RATE: rateReg_ff <= regReq.data;
        default: ;
      endcase
    end
  end

  // Code 10 is not a rate; keep the last valid report instead
  always_ff @(posedge clk)
  begin
    if (srst)
      rateSeen_ff <= 2'h0;
    else if (detectedRate != 2'h2)
      rateSeen_ff <= detectedRate;
  end

  // Registered read, one cycle after the address
  always_ff @(posedge clk)
  begin
    if (srst)
      rdData_ff <= 8'h00;
    else
    begin
      case (regReq.addr)
        `LAC_OFS_RSVD_B: rdData_ff <= rsvdB_ff;
        `LAC_OFS_RSVD_C: rdData_ff <= rsvdC_ff;
        `LAC_OFS_RSVD_D: rdData_ff <= rsvdD_ff;
        `LAC_OFS_RECEIVER_DETECT_MODE: rdData_ff <= {4'h0, rxMode_ff, 2'h0};
        `LAC_OFS_EQ: rdData_ff <= eqGain_ff;
        `LAC_OFS_RATE: rdData_ff <= rateReg_ff;
        `LAC_OFS_RATE_INFO: rdData_ff <= {1'b0, rateSeen_ff, 5'h00};
        default: rdData_ff <= 8'h00;
      endcase
    end
  end

  assign effMode = overrideRxDet ? rxMode_ff : rxDetPinMode;
  assign timerDone = (timer_ff == TW'(PROBE_CYCLES - 1));
  assign modeChanged = (effMode != lastMode_ff);

  // Detect sequencer; any mode change into code 01 or 10 restarts the probe schedule
  always_comb
  begin
    nxt_state = state_ff;
    case (effMode)
      RXD_HIZ: nxt_state = ST_OFF;
      RXD_FIXED_50: nxt_state = ST_FIXED;
      default:
      begin
        if (modeChanged || state_ff == ST_OFF || state_ff == ST_FIXED)
          nxt_state = ST_WAIT;
        else
        begin
          case (state_ff)
            ST_WAIT:
            begin
              if (receiverSeen)
                nxt_state = ST_FOUND;
              // Give up one period after the last probe, so its answer still counts
              else if (timerDone && effMode == RXD_AUTO_LIMITED &&
                       attempts_ff == AW'(PROBE_ATTEMPTS))
                nxt_state = ST_STOP;
              else
                nxt_state = ST_WAIT;
            end
            ST_FOUND: nxt_state = ST_FOUND;
            ST_STOP: nxt_state = ST_STOP;
            default: nxt_state = ST_WAIT;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_ff <= ST_OFF;
      lastMode_ff <= 2'h0;
      term50_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      lastMode_ff <= effMode;
      term50_ff <= (nxt_state == ST_FOUND) || (nxt_state == ST_FIXED);
    end
  end

  // Probe timer and attempt count, cleared outside a live wait
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      timer_ff <= '0;
      attempts_ff <= '0;
      probe_ff <= 1'b0;
    end
    else if (state_ff != ST_WAIT || nxt_state != ST_WAIT || modeChanged)
    begin
      timer_ff <= '0;
      attempts_ff <= (state_ff == ST_WAIT && !modeChanged) ? attempts_ff : '0;
      probe_ff <= 1'b0;
    end
    else if (timerDone)
    begin
      timer_ff <= '0;
      attempts_ff <= attempts_ff + AW'(1);
      probe_ff <= 1'b1;
    end
    else
    begin
      timer_ff <= timer_ff + TW'(1);
      probe_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      gen12_ff <= 1'b0;
    else
      gen12_ff <= overrideRate ? rateReg_ff[`LAC_SEL_RATE_BIT] : autoGen12;
  end

  assign regRdData = rdData_ff;
  assign link = '{probe: probe_ff, term50: term50_ff};
  assign scpEnable = rateReg_ff[`LAC_SCP_BIT];
  assign gen12Select = gen12_ff;
  assign equalizerGainLevel = eqGain_ff;

  hiz_no_probe_a: assert property (@(posedge clk) disable iff (srst)
    effMode == RXD_HIZ |=> !link.term50 ##1 !link.probe)
    else $error("probe or termination in high impedance mode");
  limit_attempts_a: assert property (@(posedge clk) disable iff (srst)
    state_ff == ST_STOP |-> !link.probe && !link.term50 && attempts_ff <= AW'(PROBE_ATTEMPTS))
    else $error("limited detect kept probing");
  probe_gap_a: assert property (@(posedge clk) disable iff (srst)
    link.probe |=> !link.probe [*8])
    else $error("probes too close together");
  fixed_term_a: assert property (@(posedge clk) disable iff (srst)
    effMode == RXD_FIXED_50 |=> link.term50 && !link.probe)
    else $error("fixed mode without 50 ohm");
  eq_reset_a: assert property (@(posedge clk)
    srst |=> equalizerGainLevel == 8'h2f)
    else $error("equalizer gain reset wrong");
  scp_follow_a: assert property (@(posedge clk) disable iff (srst)
    regReq.wrEn && regReq.addr == `LAC_OFS_RATE |=> scpEnable == $past(regReq.data[7]))
    else $error("short circuit protection not following write");
  rate_reset_a: assert property (@(posedge clk)
    srst |=> rateReg_ff == 8'hed)
    else $error("rate control reset wrong");
  rate_forced_a: assert property (@(posedge clk) disable iff (srst)
    overrideRate |=> gen12Select == $past(rateReg_ff[6]))
    else $error("forced rate not applied");
  rate_code_a: assert property (@(posedge clk) disable iff (srst)
    regReq.addr == `LAC_OFS_RATE_INFO |=> regRdData[6:5] != 2'h2)
    else $error("unused rate code reported");
  mode_select_a: assert property (@(posedge clk) disable iff (srst)
    !overrideRxDet && rxDetPinMode == RXD_FIXED_50 |=> link.term50)
    else $error("pin detect mode ignored");

endmodule : lac_chan_a_regs

`default_nettype wire

//--- lac_chan_a_regs_tb.sv
// Testbench for the channel A register bank and its detect sequencer.
// Assumes PROBE_CYCLES shortened to 20; inputs driven on falling edges.
`timescale 1ns/100ps
`default_nettype none

module lac_chan_a_regs_tb;
  import lac_pkg::*;
  logic clk, srst, ovRx, ovRate, autoGen12, clr, seen;
  logic [1:0] pinMode, detRate;
  logic [7:0] rdData, eq, answerAt, probeCnt;
  logic scp, gen12;
  lac_reg_req_type req;
  lac_link_type link;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] ofs [8] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h20};
  logic [7:0] rstv [8] = '{8'h70, 8'h00, 8'h00, 8'h00, 8'h2f, 8'hed, 8'h00, 8'h00};
  logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};

  lac_chan_a_regs #(.PROBE_CYCLES(20), .PROBE_ATTEMPTS(50)) i_lac_chan_a_regs (
    .clk(clk), .srst(srst), .regReq(req), .regRdData(rdData),
    .overrideRxDet(ovRx), .overrideRate(ovRate), .rxDetPinMode(pinMode),
    .autoGen12(autoGen12), .receiverSeen(seen), .detectedRate(detRate),
    .link(link), .scpEnable(scp), .gen12Select(gen12), .equalizerGainLevel(eq));

  lac_far_rx i_lac_far_rx (.clk(clk), .clr(clr), .answerAt(answerAt),
    .probe(link.probe), .seen(seen), .probeCnt_ff(probeCnt));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, a, d};
    idle(1);
    req.wrEn = 1'b0;
    // Spare cycle keeps the next request off the edge that drops the strobe
    idle(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.addr = a;
    idle(1);
    chk("read data", rdData, exp);
  endtask : rd

  // Clearing the model before the mode write keeps a stale presence from leaking in
  task automatic detect(input logic [7:0] m, input logic [7:0] ans, input int n,
    input logic [7:0] cnt, input logic term);
    answerAt = ans;
    clr = 1'b1;
    idle(1);
    clr = 1'b0;
    wr(8'h0e, m);
    idle(n);
    chk("probe count", probeCnt, cnt);
    chk("termination", {7'h0, link.term50}, {7'h0, term});
  endtask : detect

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      close_out();
    end
  end

  initial
  begin
    srst = 1'b1;
    req = '0;
    ovRx = 1'b0;
    ovRate = 1'b0;
    autoGen12 = 1'b1;
    pinMode = 2'h3;
    detRate = 2'h0;
    clr = 1'b1;
    answerAt = 8'h00;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    clr = 1'b0;
    foreach (ofs[i])
      rd(ofs[i], rstv[i]);
    chk("gain out", eq, 8'h2f);
    chk("protection", {7'h0, scp}, 8'h01);
    chk("pin termination", {7'h0, link.term50}, 8'h01);
    ovRx = 1'b1;
    idle(2);
    chk("reg termination", {7'h0, link.term50}, 8'h00);
    wr(8'h0f, 8'hff);
    rd(8'h0f, 8'hff);
    chk("gain out", eq, 8'hff);
    wr(8'h10, 8'h6d);
    chk("protection", {7'h0, scp}, 8'h00);
    ovRate = 1'b1;
    wr(8'h10, 8'h2d);
    idle(1);
    chk("rate select", {7'h0, gen12}, 8'h00);
    wr(8'h10, 8'hed);
    idle(1);
    chk("rate select", {7'h0, gen12}, 8'h01);
    ovRate = 1'b0;
    autoGen12 = 1'b0;
    idle(2);
    chk("rate select", {7'h0, gen12}, 8'h00);
    foreach (codes[i])
    begin
      detRate = codes[i];
      idle(1);
      rd(8'h11, {1'b0, codes[i], 5'h00});
    end
    detRate = 2'h2;
    idle(2);
    rd(8'h11, 8'h60);
    detect(8'h00, 8'h00, 100, 8'h00, 1'b0);
    detect(8'h0c, 8'h00, 40, 8'h00, 1'b1);
    detect(8'h04, 8'h00, 1100, 8'h32, 1'b0);
    detect(8'h08, 8'h03, 200, 8'h03, 1'b1);
    detect(8'h04, 8'h02, 200, 8'h02, 1'b1);
    close_out();
  end
endmodule : lac_chan_a_regs_tb

`default_nettype wire

//--- lac_defines.svh
// Register offsets, reset values, field positions and timing counts for channel A config.
// Assumes inclusion by bare name from the design module.
`ifndef LAC_DEFINES_SVH
`define LAC_DEFINES_SVH

`define LAC_OFS_RSVD_B 8'h0b
`define LAC_OFS_RSVD_C 8'h0c
`define LAC_OFS_RSVD_D 8'h0d
`define LAC_OFS_RECEIVER_DETECT_MODE 8'h0e
`define LAC_OFS_EQ 8'h0f
`define LAC_OFS_RATE 8'h10
`define LAC_OFS_RATE_INFO 8'h11

`define LAC_RST_RSVD_B 8'h70
`define LAC_RST_RSVD_C 8'h00
`define LAC_RST_RSVD_D 8'h00
`define LAC_RST_RECEIVER_DETECT_MODE 2'h0
`define LAC_RST_EQ 8'h2f
`define LAC_RST_RATE 8'hed

`define LAC_RECEIVER_DETECT_MODE_HI 3
`define LAC_RECEIVER_DETECT_MODE_LO 2
`define LAC_SCP_BIT 7
`define LAC_SEL_RATE_BIT 6
`define LAC_RATE_INFO_HI 6
`define LAC_RATE_INFO_LO 5

`define LAC_CLK_KHZ 20000
`define LAC_PROBE_MS 12
`define LAC_PROBE_LIMIT_MS 600
`define LAC_PROBE_CYCLES (`LAC_PROBE_MS * `LAC_CLK_KHZ)
`define LAC_PROBE_ATTEMPTS (`LAC_PROBE_LIMIT_MS / `LAC_PROBE_MS)

`endif

//--- lac_far_rx.sv
// Far-side receiver model: counts probe pulses and reports presence.
// Assumes probe pulses are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module lac_far_rx
(
  // Clock and bench control
  input wire logic clk,
  input wire logic clr,
  input wire logic [7:0] answerAt,
  // Link side
  input wire logic probe,
  output logic seen,
  output logic [7:0] probeCnt_ff
);
  always_ff @(posedge clk)
    if (clr)
      probeCnt_ff <= 8'h00;
    else if (probe)
      probeCnt_ff <= probeCnt_ff + 8'h01;
  // Zero means no receiver ever answers, so a limited search must give up
  assign seen = (answerAt != 8'h00) && (probeCnt_ff >= answerAt);
endmodule : lac_far_rx

`default_nettype wire

//--- lac_pkg.sv
// Types for the channel A configuration register bank.
// Assumes nothing beyond the defines header.
package lac_pkg;

  typedef enum logic [1:0] {
    RXD_HIZ = 2'h0,
    RXD_AUTO_LIMITED = 2'h1,
    RXD_AUTO_FOREVER = 2'h2,
    RXD_FIXED_50 = 2'h3
  } lac_receiver_detect_mode_type;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_WAIT = 5'h02,
    ST_FOUND = 5'h04,
    ST_STOP = 5'h08,
    ST_FIXED = 5'h10
  } lac_state_type;

  typedef struct packed {
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] data;
  } lac_reg_req_type;

  typedef struct packed {
    logic probe;
    logic term50;
  } lac_link_type;

endpackage : lac_pkg
